// File: src/mq_pkg.sv
// Constants, types and helpers shared by the queue setup front end.
// Assumes one write clock domain; strap, slot and serial pin levels are synchronised in mq_front.
package mq_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_Q = 4;
  localparam int HDR_BITS = 19;
  localparam int SET_BITS = 72;
  localparam int FIELD_W = 24;
  localparam int HDR_Q_LSB = SET_BITS - HDR_BITS;
  localparam int SLOT_W = 3;
  // ****************************************
  // Default load values
  // ****************************************
  localparam logic [23:0] DEPTH_X9 = 24'h004000;
  localparam logic [23:0] DEPTH_X18 = 24'h002000;
  localparam logic [23:0] OFS_LOW = 24'h000008;
  localparam logic [23:0] OFS_HIGH = 24'h000080;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DEPTH = 8'h08;
  localparam logic [7:0] ADDR_AE = 8'h0c;
  localparam logic [7:0] ADDR_AF = 8'h10;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_SEL_LSB = 2;

  typedef enum logic [1:0] {CFG_IDLE, CFG_SERIAL, CFG_DEFAULT, CFG_READY} cfg_state_t;

  function automatic logic [8:0] cfg_bits(input logic [2:0] q);
    return 9'(HDR_BITS + SET_BITS * int'(q));
  endfunction
endpackage

// File: src/setup_load_if.sv
// Carries decoded queue setup sets from the serial loader to the store.
// Assumes both ends share the write clock.
`timescale 1ns/1ns
interface setup_load_if;
  logic valid;
  logic [1:0] idx;
  logic [23:0] depth;
  logic [23:0] ae;
  logic [23:0] af;
  logic [2:0] nq;
  logic done;
  modport src(output valid, idx, depth, ae, af, nq, done);
  modport dst(input valid, idx, depth, ae, af, nq, done);
endinterface

// File: src/setup_loader.sv
// Serial setup stream decoder: header, then one 72-bit set per queue.
// Assumes shift pulses are already synchronised single-cycle strobes.
`timescale 1ns/1ns
module setup_loader (
  input wire logic clk, // Write clock
  input wire logic rst_n, // Async reset
  input wire logic clear, // Held in master reset
  input wire logic shift, // One accepted serial bit
  input wire logic bit_in, // Serial bit value
  setup_load_if.src lb // Decoded sets
);
  logic [71:0] sr_ff;
  logic [71:0] nxt_sr;
  logic [8:0] cnt_ff;
  logic [6:0] seg_ff;
  logic [1:0] idx_ff;
  logic hdr_ff;
  logic last_seg;
  logic take;

  assign nxt_sr = {bit_in, sr_ff[71:1]};
  assign last_seg = hdr_ff && (seg_ff == 7'(mq_pkg::SET_BITS - 1));
  assign take = shift && !lb.done && !clear;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_ff <= '0;
      cnt_ff <= 9'h000;
      seg_ff <= 7'h00;
      idx_ff <= 2'h0;
      hdr_ff <= 1'b0;
      lb.nq <= 3'h0;
      lb.done <= 1'b0;
    end else if (clear) begin
      cnt_ff <= 9'h000;
      seg_ff <= 7'h00;
      idx_ff <= 2'h0;
      hdr_ff <= 1'b0;
      lb.nq <= 3'h0;
      lb.done <= 1'b0;
    end else if (take) begin
      sr_ff <= nxt_sr;
      cnt_ff <= cnt_ff + 9'h001;
      if (!hdr_ff) begin
        if (cnt_ff == 9'(mq_pkg::HDR_BITS - 1)) begin
          hdr_ff <= 1'b1;
          lb.nq <= {1'b0, nxt_sr[mq_pkg::HDR_Q_LSB +: 2]} + 3'h1;
        end
      end else begin
        seg_ff <= last_seg ? 7'h00 : seg_ff + 7'h01;
      end
      if (last_seg) begin
        idx_ff <= idx_ff + 2'h1;
      end
      if (hdr_ff && (cnt_ff + 9'h001 == mq_pkg::cfg_bits(lb.nq))) begin
        lb.done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lb.valid <= 1'b0;
      lb.idx <= 2'h0;
      lb.depth <= 24'h000000;
      lb.ae <= 24'h000000;
      lb.af <= 24'h000000;
    end else begin
      lb.valid <= take && last_seg;
      lb.idx <= idx_ff;
      lb.depth <= nxt_sr[23:0];
      lb.ae <= nxt_sr[47:24];
      lb.af <= nxt_sr[71:48];
    end
  end

  property p_bit_count;
    @(posedge clk) disable iff (!rst_n)
    $rose(lb.done) |-> cnt_ff == mq_pkg::cfg_bits(lb.nq);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("setup done at wrong bit count");
endmodule

// File: src/wr_queue_select.sv
// Write queue selection pipeline and write gating for the shared write port.
// Assumes the queue full vector is from storage logic on the same clock.
`timescale 1ns/1ns
module wr_queue_select (
  input wire logic clk, // Write clock
  input wire logic rst_n, // Async reset
  input wire logic enable, // Setup complete
  input wire logic capture, // Address capture strobe
  input wire logic [4:0] addr, // Write queue address
  input wire logic [2:0] slot, // Device slot pins
  input wire logic wr_en_n, // Write enable, low active
  input wire logic hold, // Software write hold
  input wire logic [3:0] queue_full, // Per queue full
  output logic full_flag, // Selected queue full
  output logic owned, // This device holds the port
  output logic [1:0] act_q, // Queue taking writes
  output logic push, // Write accepted
  output logic [1:0] push_q // Queue of accepted write
);
  logic ph_ff;
  logic new_own_ff;
  logic [1:0] new_q_ff;
  logic sel_any;
  logic sel_hit;
  logic wr_go;

  // Address pulses before setup completes are ignored
  assign sel_any = enable && capture;
  assign sel_hit = sel_any && (addr[4:2] == slot);
  assign wr_go = enable && !wr_en_n && !hold && owned && !queue_full[act_q];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 1'b0;
      new_q_ff <= 2'h0;
      new_own_ff <= 1'b0;
    end else begin
      ph_ff <= sel_any;
      if (sel_any) begin
        new_q_ff <= addr[1:0];
        new_own_ff <= sel_hit;
      end
    end
  end

  // Active queue switches one edge late so two writes still reach the old one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 2'h0;
      owned <= 1'b0;
      full_flag <= 1'b1;
    end else if (!enable) begin
      owned <= 1'b0;
      full_flag <= 1'b1;
    end else if (ph_ff) begin
      act_q <= new_q_ff;
      owned <= new_own_ff;
      full_flag <= new_own_ff ? queue_full[new_q_ff] : 1'b1;
    end else begin
      full_flag <= owned ? queue_full[act_q] : 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      push <= 1'b0;
      push_q <= 2'h0;
    end else begin
      push <= wr_go;
      push_q <= act_q;
    end
  end

  property p_sel_take;
    @(posedge clk) disable iff (!rst_n)
    sel_hit ##1 !sel_any |=> owned && act_q == $past(addr[1:0], 2);
  endproperty
  a_sel_take: assert property (p_sel_take) else $error("selection not taken");

  property p_full_update;
    @(posedge clk) disable iff (!rst_n)
    sel_hit ##1 enable |=> full_flag == $past(queue_full[new_q_ff]);
  endproperty
  a_full_update: assert property (p_full_update) else $error("full flag stale");

  property p_old_queue;
    @(posedge clk) disable iff (!rst_n)
    sel_any && owned ##1 push |-> push_q == $past(act_q);
  endproperty
  a_old_queue: assert property (p_old_queue) else $error("early write to new queue");

  property p_no_full_write;
    @(posedge clk) disable iff (!rst_n)
    push |-> !$past(queue_full[act_q]);
  endproperty
  a_no_full_write: assert property (p_no_full_write) else $error("write into full");
endmodule

// File: src/mq_front.sv
// Queue setup and write-select front end of a four queue flow-control device.
// Assumes APB master on CLOCK; strap, slot and serial pins are asynchronous.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
// Contract
// - Low default select waits for serial stream
// - One setup set per queue, four sets
// - Stream is 19 plus 72 per queue
// - Sample serial bit when enable low
// - Done output mirrors input enable after setup
// - Serial output follows input after setup
// - Chain needs n times device bits
// - Default mode: no serial, four equal queues
// - Default depth by port width, scaled
// - Offset preset picks 8 or 128
// - Default load signals done falling
// - Capture edge takes write queue address
// - Selection persists until next selection
// - Full flag follows new queue next edge
// - Two writes to old queue, then new
// - No write into a full queue
// - Five bit address, slot match upper three
// - Strobe selects flag bus owner by slot
// - No writes until setup finished
module mq_front #(
  parameter int DATA_W = 18,
  parameter int MEM_SCALE = 1
) (
  input wire logic CLOCK, // Write clock, 10 MHz
  input wire logic NRST, // Async reset, low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input wire logic MASTER_RESET_N, // Master reset pin
  input wire logic DEFAULT_LOAD_SELECT, // Strap: default load
  input wire logic OFFSET_PRESET_SELECT, // Strap: offset preset
  input wire logic PORT_WIDE18, // Strap: a port is 18 wide
  input wire logic DEVICE_SLOT_BIT0, // Slot pin 0
  input wire logic DEVICE_SLOT_BIT1, // Slot pin 1
  input wire logic DEVICE_SLOT_BIT2, // Slot pin 2
  input wire logic CFG_SCLK, // Serial clock pin
  input wire logic CFG_SI, // Serial data in
  input wire logic CFG_SHIFT_ENABLE_IN_N, // Serial enable in
  output logic CFG_SO, // Serial data out
  output logic CFG_CHAIN_DONE_OUT_N, // Chain done out
  output logic CFG_READY, // Setup complete
  input wire logic [4:0] WR_QUEUE_ADDR, // Write queue address
  input wire logic WR_ADDR_CAPTURE, // Address capture
  input wire logic WR_EN_N, // Write enable, low
  input wire logic [DATA_W-1:0] WR_DATA_IN, // Write data
  input wire logic ALMOST_FULL_BUS_STROBE, // Flag bus strobe
  input wire logic [3:0] QUEUE_FULL, // Per queue full
  input wire logic [3:0] QUEUE_ALMOST_FULL, // Per queue almost full
  output logic FULL_FLAG, // Selected queue full
  output logic [3:0] ALMOST_FULL_FLAG, // Flag bus value
  output logic ALMOST_FULL_FLAG_OE, // Flag bus drive
  output logic PUSH_VALID, // Write to queue
  output logic [1:0] PUSH_QUEUE, // Target queue
  output logic [DATA_W-1:0] PUSH_DATA // Data to queue
);
  // ****************************************
  // Parameter checks
  // ****************************************
  if (DATA_W != 9 && DATA_W != 18) begin : g_bad_w
    $error("DATA_W must be 9 or 18");
  end
  if (MEM_SCALE != 1 && MEM_SCALE != 2 && MEM_SCALE != 4) begin : g_bad_s
    $error("MEM_SCALE must be 1, 2 or 4");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [9:0] pin_s1_ff;
  logic [9:0] pin_s2_ff;
  logic sclk_d_ff;
  logic mrn_d_ff;
  logic mrn_s;
  logic sclk_s;
  logic si_s;
  logic cfg_shift_enable_in_n_s;
  logic [2:0] slot_s;
  logic sclk_rise;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_s1_ff <= 10'h000;
      pin_s2_ff <= 10'h000;
      sclk_d_ff <= 1'b0;
      mrn_d_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {MASTER_RESET_N, DEFAULT_LOAD_SELECT, OFFSET_PRESET_SELECT,
                    PORT_WIDE18, DEVICE_SLOT_BIT2, DEVICE_SLOT_BIT1,
                    DEVICE_SLOT_BIT0, CFG_SCLK, CFG_SI, CFG_SHIFT_ENABLE_IN_N};
      pin_s2_ff <= pin_s1_ff;
      sclk_d_ff <= sclk_s;
      mrn_d_ff <= mrn_s;
    end
  end

  assign mrn_s = pin_s2_ff[9];
  assign slot_s = pin_s2_ff[5:3];
  assign sclk_s = pin_s2_ff[2];
  assign si_s = pin_s2_ff[1];
  assign cfg_shift_enable_in_n_s = pin_s2_ff[0];
  assign sclk_rise = sclk_s && !sclk_d_ff;

  // ****************************************
  // Master reset sequencing
  // ****************************************
  mq_pkg::cfg_state_t state_ff;
  logic dfm_ff;
  logic df_ff;
  logic wide_ff;
  logic [1:0] def_idx_ff;
  logic [2:0] nq_ff;
  logic ready;
  logic shift;
  setup_load_if lb ();

  assign ready = (state_ff == mq_pkg::CFG_READY);
  // Serial bits only count outside default mode
  assign shift = (state_ff == mq_pkg::CFG_SERIAL) && sclk_rise && !cfg_shift_enable_in_n_s;

  // Straps are caught by the clock while master reset is low
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= mq_pkg::CFG_IDLE;
      dfm_ff <= 1'b0;
      df_ff <= 1'b0;
      wide_ff <= 1'b0;
      def_idx_ff <= 2'h0;
    end else if (!mrn_s) begin
      state_ff <= mq_pkg::CFG_IDLE;
      dfm_ff <= pin_s2_ff[8];
      df_ff <= pin_s2_ff[7];
      wide_ff <= pin_s2_ff[6];
      def_idx_ff <= 2'h0;
    end else begin
      case (state_ff)
        mq_pkg::CFG_IDLE: begin
          if (!mrn_d_ff) begin
            state_ff <= dfm_ff ? mq_pkg::CFG_DEFAULT : mq_pkg::CFG_SERIAL;
          end
        end
        mq_pkg::CFG_SERIAL: begin
          if (lb.done) begin
            state_ff <= mq_pkg::CFG_READY;
          end
        end
        mq_pkg::CFG_DEFAULT: begin
          def_idx_ff <= def_idx_ff + 2'h1;
          if (def_idx_ff == 2'(mq_pkg::NUM_Q - 1)) begin
            state_ff <= mq_pkg::CFG_READY;
          end
        end
        default: begin
          state_ff <= mq_pkg::CFG_READY;
        end
      endcase
    end
  end

  setup_loader u_loader (
    .clk(CLOCK),
    .rst_n(NRST),
    .clear(state_ff == mq_pkg::CFG_IDLE),
    .shift(shift),
    .bit_in(si_s),
    .lb(lb.src)
  );

  // ****************************************
  // Setup register sets
  // ****************************************
  logic [23:0] depth_mem [mq_pkg::NUM_Q];
  logic [23:0] ae_mem [mq_pkg::NUM_Q];
  logic [23:0] af_mem [mq_pkg::NUM_Q];
  logic [23:0] def_depth;
  logic [23:0] def_ofs;

  assign def_depth = 24'((wide_ff ? mq_pkg::DEPTH_X18 : mq_pkg::DEPTH_X9) * MEM_SCALE);
  assign def_ofs = df_ff ? mq_pkg::OFS_HIGH : mq_pkg::OFS_LOW;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < mq_pkg::NUM_Q; i++) begin
        depth_mem[i] <= 24'h000000;
        ae_mem[i] <= 24'h000000;
        af_mem[i] <= 24'h000000;
      end
    end else if (state_ff == mq_pkg::CFG_DEFAULT) begin
      depth_mem[def_idx_ff] <= def_depth;
      ae_mem[def_idx_ff] <= def_ofs;
      af_mem[def_idx_ff] <= def_ofs;
    end else if (lb.valid) begin
      depth_mem[lb.idx] <= lb.depth;
      ae_mem[lb.idx] <= lb.ae;
      af_mem[lb.idx] <= lb.af;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      nq_ff <= 3'h0;
    end else if (state_ff == mq_pkg::CFG_DEFAULT) begin
      nq_ff <= 3'(mq_pkg::NUM_Q);
    end else if (state_ff == mq_pkg::CFG_SERIAL) begin
      nq_ff <= lb.nq;
    end
  end

  // ****************************************
  // Serial chain outputs
  // ****************************************
  // Both outputs lag the pins by the synchroniser depth plus the output register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      CFG_CHAIN_DONE_OUT_N <= 1'b1;
      CFG_SO <= 1'b0;
      CFG_READY <= 1'b0;
    end else begin
      CFG_CHAIN_DONE_OUT_N <= ready ? cfg_shift_enable_in_n_s : 1'b1;
      CFG_SO <= ready ? si_s : 1'b0;
      CFG_READY <= ready;
    end
  end

  // ****************************************
  // Write port
  // ****************************************
  logic [31:0] ctrl_ff;
  logic owned;
  logic [1:0] act_q;
  logic push;
  logic [1:0] push_q;

  wr_queue_select u_wsel (
    .clk(CLOCK),
    .rst_n(NRST),
    .enable(ready),
    .capture(WR_ADDR_CAPTURE),
    .addr(WR_QUEUE_ADDR),
    .slot(slot_s),
    .wr_en_n(WR_EN_N),
    .hold(ctrl_ff[mq_pkg::CTRL_HOLD_BIT]),
    .queue_full(QUEUE_FULL),
    .full_flag(FULL_FLAG),
    .owned(owned),
    .act_q(act_q),
    .push(push),
    .push_q(push_q)
  );

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PUSH_DATA <= '0;
    end else begin
      PUSH_DATA <= WR_DATA_IN;
    end
  end

  assign PUSH_VALID = push;
  assign PUSH_QUEUE = push_q;

  // ****************************************
  // Almost-full flag bus
  // ****************************************
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ALMOST_FULL_FLAG_OE <= 1'b0;
      ALMOST_FULL_FLAG <= 4'h0;
    end else begin
      if (!WR_ADDR_CAPTURE && ALMOST_FULL_BUS_STROBE) begin
        ALMOST_FULL_FLAG_OE <= ready && (WR_QUEUE_ADDR[4:2] == slot_s);
      end
      ALMOST_FULL_FLAG <= QUEUE_ALMOST_FULL;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic [31:0] rd_word;
  logic [1:0] set_sel;

  function automatic logic mapped(input logic [7:0] a);
    return a == mq_pkg::ADDR_STATUS || a == mq_pkg::ADDR_CTRL ||
           a == mq_pkg::ADDR_DEPTH || a == mq_pkg::ADDR_AE || a == mq_pkg::ADDR_AF;
  endfunction

  assign set_sel = ctrl_ff[mq_pkg::CTRL_SEL_LSB +: 2];
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);

  always_comb begin
    rd_word = 32'h00000000;
    if (PADDR == mq_pkg::ADDR_STATUS) begin
      rd_word = {21'h000000, FULL_FLAG, owned, act_q, nq_ff, wide_ff, df_ff, dfm_ff, ready};
    end else if (PADDR == mq_pkg::ADDR_CTRL) begin
      rd_word = ctrl_ff;
    end else if (PADDR == mq_pkg::ADDR_DEPTH) begin
      rd_word = {8'h00, depth_mem[set_sel]};
    end else if (PADDR == mq_pkg::ADDR_AE) begin
      rd_word = {8'h00, ae_mem[set_sel]};
    end else if (PADDR == mq_pkg::ADDR_AF) begin
      rd_word = {8'h00, af_mem[set_sel]};
    end
  end

  // Read data is latched in the setup phase, so every access is zero wait
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rd_word;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ctrl_ff <= mq_pkg::CTRL_RST;
    end else if (PSEL && PENABLE && PWRITE && PADDR == mq_pkg::ADDR_CTRL) begin
      ctrl_ff <= PWDATA & 32'h0000000d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  property p_shift_gate;
    shift |-> !cfg_shift_enable_in_n_s && !dfm_ff && state_ff == mq_pkg::CFG_SERIAL;
  endproperty
  a_shift_gate: assert property (p_shift_gate) else $error("bit taken while disabled");

  property p_done_mirror;
    ready |=> CFG_CHAIN_DONE_OUT_N == $past(cfg_shift_enable_in_n_s);
  endproperty
  a_done_mirror: assert property (p_done_mirror) else $error("done output not mirroring");

  property p_so_follow;
    ready |=> CFG_SO == $past(si_s);
  endproperty
  a_so_follow: assert property (p_so_follow) else $error("serial out not following");

  property p_not_ready_idle;
    !ready |=> CFG_CHAIN_DONE_OUT_N && !PUSH_VALID ##1 !PUSH_VALID;
  endproperty
  a_not_ready_idle: assert property (p_not_ready_idle) else $error("activity before setup");

  property p_default_sets;
    ready && dfm_ff |-> nq_ff == 3'h4 && depth_mem[3] == def_depth && af_mem[0] == def_ofs;
  endproperty
  a_default_sets: assert property (p_default_sets) else $error("default sets wrong");

  property p_default_ofs;
    ready && dfm_ff |-> ae_mem[2] == (df_ff ? 24'h000080 : 24'h000008);
  endproperty
  a_default_ofs: assert property (p_default_ofs) else $error("default offset wrong");

  property p_default_time;
    $rose(mrn_s) && pin_s2_ff[8] |-> ##6 ready;
  endproperty
  a_default_time: assert property (p_default_time) else $error("default load late");

  property p_af_bus;
    ready && !WR_ADDR_CAPTURE && ALMOST_FULL_BUS_STROBE
      |=> ALMOST_FULL_FLAG_OE == ($past(WR_QUEUE_ADDR[4:2]) == slot_s);
  endproperty
  a_af_bus: assert property (p_af_bus) else $error("flag bus owner wrong");

  c_serial_done: cover property ($rose(ready) && !dfm_ff);
  c_default_done: cover property ($rose(ready) && dfm_ff);
  c_select: cover property (ready && WR_ADDR_CAPTURE ##2 PUSH_VALID);
  c_full_block: cover property (ready && !WR_EN_N && FULL_FLAG);
endmodule

// File: tb/cfg_host.sv
// Host side of the serial setup port: shifts a stream and watches done.
// Assumes the device samples the serial pins through synchronisers on clk.
`timescale 1ns/1ns
module cfg_host (
  input wire logic clk, // Device write clock
  input wire logic done_n, // Chain done from device
  output logic sclk, // Serial clock, still between frames
  output logic si, // Serial data
  output logic sen_n // Shift enable, low
);
  initial begin
    sclk = 1'b0;
    si = 1'b0;
    sen_n = 1'b1;
  end
  task automatic en(input logic v);
    @(posedge clk);
    sen_n <= v;
  endtask
  // Half period in clocks; slow enough for the synchronisers
  task automatic send(input logic [90:0] s, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      si <= s[i];
      sen_n <= 1'b0;
      repeat (half) @(posedge clk);
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
    end
    for (int k = 0; k < 20 && done_n !== 1'b0; k++) @(posedge clk);
    @(posedge clk);
    sen_n <= 1'b1;
    si <= ~si;
  endtask
endmodule

// File: tb/multiqueue_setup_and_write_select_tb.sv
// Bench for the queue setup and write select front end.
// Assumes cfg_host drives the serial pins; slot pins strapped to 3'h5.
`timescale 1ns/1ns
module multiqueue_setup_and_write_select_tb;
  localparam logic [2:0] SLOT = 3'h5;
  logic clk, rdy, ff, oe, pv, so, done_n, sclk, si, sen_n, pready, perr;
  logic nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, mrst_n = 1'b1;
  logic dflt = 1'b0, ofs = 1'b0, wide = 1'b0, cap = 1'b0, wen_n = 1'b1, strb = 1'b0;
  logic own = 1'b0;
  logic [1:0] pq, act = 2'h0;
  logic [3:0] qf = 4'h0, afb;
  logic [4:0] wa = 5'h0;
  logic [7:0] pa = 8'h0;
  logic [17:0] din = 18'h0, pdat;
  logic [23:0] dep;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [1:0] pushes[$];
  int num_errors = 0, tests_run = 0;
  mq_front #(.DATA_W(18), .MEM_SCALE(1)) dut (.CLOCK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready),
    .PSLVERR(perr), .MASTER_RESET_N(mrst_n), .DEFAULT_LOAD_SELECT(dflt),
    .OFFSET_PRESET_SELECT(ofs), .PORT_WIDE18(wide), .DEVICE_SLOT_BIT0(SLOT[0]),
    .DEVICE_SLOT_BIT1(SLOT[1]), .DEVICE_SLOT_BIT2(SLOT[2]), .CFG_SCLK(sclk), .CFG_SI(si),
    .CFG_SHIFT_ENABLE_IN_N(sen_n), .CFG_SO(so), .CFG_CHAIN_DONE_OUT_N(done_n),
    .CFG_READY(rdy), .WR_QUEUE_ADDR(wa), .WR_ADDR_CAPTURE(cap), .WR_EN_N(wen_n),
    .WR_DATA_IN(din), .ALMOST_FULL_BUS_STROBE(strb), .QUEUE_FULL(qf),
    .QUEUE_ALMOST_FULL(qf), .FULL_FLAG(ff), .ALMOST_FULL_FLAG(afb),
    .ALMOST_FULL_FLAG_OE(oe), .PUSH_VALID(pv), .PUSH_QUEUE(pq), .PUSH_DATA(pdat));
  cfg_host host (.clk(clk), .done_n(done_n), .sclk(sclk), .si(si), .sen_n(sen_n));
  always @(posedge clk) if (pv === 1'b1) pushes.push_back(pq);
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Capture and writes held during master reset must be ignored
  task automatic mreset(input logic d, input logic o, input logic w);
    pushes.delete();
    @(posedge clk);
    dflt <= d;
    ofs <= o;
    wide <= w;
    mrst_n <= 1'b0;
    // Strobes wait until the low pin has passed the synchroniser
    repeat (4) @(posedge clk);
    cap <= 1'b1;
    wen_n <= 1'b0;
    wa <= {SLOT, 2'h1};
    repeat (4) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (3) @(posedge clk);
    cap <= 1'b0;
    wen_n <= 1'b1;
    chk("ff_idle", 32'(ff), 32'h1);
    chk("no_push", 32'(pushes.size()), 32'h0);
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 3000 && rdy !== 1'b1; i++) @(posedge clk);
    chk("ready", 32'(rdy), 32'h1);
  endtask
  task automatic trial(input logic [1:0] q, input logic m);
    logic [3:0] f;
    int n;
    f = 4'($urandom());
    n = (own && !f[act]) ? 2 : 0;
    pushes.delete();
    @(posedge clk);
    qf <= f;
    cap <= 1'b1;
    wen_n <= 1'b0;
    din <= 18'($urandom());
    wa <= {m ? SLOT : ~SLOT, q};
    @(posedge clk);
    cap <= 1'b0;
    @(posedge clk);
    #1 chk("ff", 32'(ff), 32'(m ? f[q] : 1'b1));
    repeat (2) @(posedge clk);
    wen_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("npush", 32'(pushes.size()), 32'(n + ((m && !f[q]) ? 2 : 0)));
    foreach (pushes[i]) chk("pushq", 32'(pushes[i]), 32'(i < n ? act : q));
    chk("pdat", 32'(pdat), 32'(din));
    act = q;
    own = m;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #3000000;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(32'h64fb91c4));
    repeat (6) @(posedge clk);
    chk("rst_done", 32'(done_n), 32'h1);
    nrst <= 1'b1;
    host.en(1'b0);
    for (int i = 0; i < 2; i++) begin
      mreset(1'b1, i[0], i[0]);
      wait_rdy();
      chk("done_dflt", 32'(done_n), 32'h0);
      apb(1'b1, mq_pkg::ADDR_CTRL, 32'h0000000c);
      apb(1'b0, mq_pkg::ADDR_DEPTH, 32'h0);
      chk("depth", rd, i ? 32'h00002000 : 32'h00004000);
      apb(1'b0, mq_pkg::ADDR_AF, 32'h0);
      chk("af", rd, i ? 32'h00000080 : 32'h00000008);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", {rd[30:0], perr}, 32'h1);
    host.en(1'b1);
    mreset(1'b0, 1'b0, 1'b1);
    repeat (20) @(posedge clk);
    chk("rdy_wait", 32'(rdy), 32'h0);
    dep = 24'($urandom_range(4095, 16));
    host.send({24'h7, 24'h5, dep, 19'h0}, 91, 4);
    chk("done_lo", 32'(done_n), 32'h0);
    wait_rdy();
    repeat (6) @(posedge clk);
    chk("done_hi", 32'(done_n), 32'h1);
    chk("so", 32'(so), 32'(si));
    apb(1'b1, mq_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, mq_pkg::ADDR_DEPTH, 32'h0);
    chk("depth_s", rd, 32'(dep));
    trial(2'h3, 1'b1);
    for (int i = 0; i < 14; i++) trial(2'($urandom()), $urandom_range(3, 0) != 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      strb <= 1'b1;
      wa <= {i ? ~SLOT : SLOT, 2'h2};
      @(posedge clk);
      strb <= 1'b0;
      @(posedge clk);
      chk("flag_oe", 32'(oe), 32'(i == 0));
      chk("afb", 32'(afb), 32'(qf));
    end
    results();
  end
endmodule
